//--- core/io_sample_framer_defs.svh
// Offsets, field positions, reset values and timing counts of the I/O sample framer
`ifndef IO_SAMPLE_FRAMER_DEFS_SVH
`define IO_SAMPLE_FRAMER_DEFS_SVH

`define OFS_CTRL           8'h00
`define OFS_DIGITAL_MASK   8'h04
`define OFS_ANALOG_MASK    8'h08
`define OFS_PERIOD_MS      8'h0c
`define OFS_DEST_ADDR      8'h10
`define OFS_DEST_OPT       8'h14
`define OFS_AREF_SEL       8'h18
`define OFS_WAKE_DIV       8'h1c
`define OFS_CHANGE_MASK    8'h20
`define OFS_FORCE          8'h24
`define OFS_STATUS         8'h28

`define CTRL_TEXT_BIT      0
`define FORCE_LOCAL_BIT    0
`define FORCE_REMOTE_BIT   1
`define OPT_CLOUD_BIT      0
`define OPT_DEST_BIT       3

`define AREF_RESET         1'b1
`define SET_COUNT_BYTE     8'h01
`define TEXT_SEP_BYTE      8'h0d

`define CLK_PERIOD_NS      40
`define MS_NS              1000000
`define CYCLES_PER_MS      (`MS_NS / `CLK_PERIOD_NS)
`define MIN_GAP_MS         2'd3

`endif

//--- core/io_sample_framer_pkg.sv
// Types of the I/O sample framer
package io_sample_framer_pkg;

    typedef enum logic [3:0] {
        PH_IDLE   = 4'b0000,
        PH_SETCNT = 4'b0001,
        PH_DMASKH = 4'b0010,
        PH_DMASKL = 4'b0011,
        PH_AMASK  = 4'b0100,
        PH_DSTH   = 4'b0101,
        PH_DSTL   = 4'b0110,
        PH_ANAH   = 4'b0111,
        PH_ANAL   = 4'b1000
    } phase_t;

    // Trigger sources, index into the pending vector, highest priority first
    typedef enum logic [2:0] {
        TR_LOCAL  = 3'd0,
        TR_REMOTE = 3'd1,
        TR_WAKE   = 3'd2,
        TR_CHANGE = 3'd3,
        TR_PERIOD = 3'd4
    } trig_t;

    typedef struct packed {
        logic to_serial;
        logic to_requester;
        logic to_dest;
        logic to_cloud;
    } route_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        text_mode;
        logic [12:0] dmask;
        logic [3:0]  amask;
        logic [15:0] period;
        logic [31:0] dest;
        logic [7:0]  dopt;
        logic        aref;
        logic [7:0]  wake_div;
        logic [12:0] chg_mask;
        logic [12:0] ln_s1;
        logic [12:0] ln_s2;
        logic [12:0] ln_prev;
        logic        awake_s1;
        logic        awake_s2;
        logic        awake_prev;
        logic [4:0]  pend;
        logic [15:0] tick_cnt;
        logic [15:0] ms_cnt;
        logic [1:0]  gap;
        logic [7:0]  wake_cnt;
        logic        wake_ok;
        phase_t      phase;
        trig_t       src;
        logic        sep;
        logic [1:0]  ch;
        logic [12:0] snap_d;
        logic [39:0] snap_a;
        logic        valid;
        logic [7:0]  data;
        logic        rec_end;
        route_t      route;
        logic        framed;
        logic        err;
        route_t      err_route;
    } state_t;

endpackage : io_sample_framer_pkg

//--- core/io_sample_framer.sv
// APB-controlled I/O sample record framer
//
// How it works
// R1 - Record order: set count, digital mask, analog mask, then sampled data.
// R2 - First byte is a set count, always one.
// R3 - Two-byte digital mask, bit n marks digital line n, lines 0 to 12.
// R4 - One-byte analog mask, bits 0 to 3 flag analog channels 0 to 3.
// R5 - Two digital-state bytes come first only when some digital line is enabled.
// R6 - State bits of disabled lines carry no meaning; receivers ignore them.
// R7 - Two bytes per enabled analog channel follow, ascending, disabled ones skipped.
// R8 - Analog value is a 10-bit code right-aligned in 16 bits, capped at 0x3ff.
// R9 - Reference select picks 1.25 V or 2.5 V; 2.5 V after reset.
// R10 - Force request with some line enabled samples everything enabled, one record.
// R11 - Force request with no line enabled returns an error instead.
// R12 - Local force goes to the serial port, remote force back to the requester.
// R13 - Text mode separates fields with carriage returns; otherwise a response frame. The code uses text mode only for local force records.
// R14 - Periodic sampling off when period is zero or no line active.
// R15 - Samples go out at most once per three ms; faster periods lose samples. The code holds back only periodic samples this way.
// R16 - Destination options 0x09 send periodic samples to cloud and destination.
// R17 - Without cloud reporting periodic samples go only to the destination address.
// R18 - A peer destination must run framed mode, else it drops samples.
// R19 - While awake, periodic samples continue at the set period until sleep.
// R20 - Each counted wake-up sends one sample at once.
// R21 - Wake cycles counted against a divider; periodic only on elapsed cycles.
// R22 - A change on a monitored digital line sends a sample at once.
// R23 - Triggers arriving during a record are held until it completes.
`timescale 1ns/1ps
`include "io_sample_framer_defs.svh"

module io_sample_framer
    import io_sample_framer_pkg::*;
#(
    parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic [31:0]      prdata_out,
    output logic             pslverr_out,
    input  wire logic [12:0] digital_line_in,
    input  wire logic [39:0] analog_channel_in,
    input  wire logic        awake_in,
    input  wire logic        rec_ready_in,
    output logic             rec_valid_out,
    output logic [7:0]       rec_data_out,
    output logic             rec_end_out,
    output route_t           rec_route_out,
    output logic             rec_framed_out,
    output logic             force_error_out,
    output route_t           error_route_out,
    output logic [31:0]      destination_address_out,
    output logic             analog_reference_select_out
);

    state_t s_ff;
    state_t nxt_s;

    // Next enabled analog channel at or above a start index
    function automatic logic [2:0] find_ch(input logic [3:0] mask, input logic [2:0] from);
        logic [2:0] res;
        res = 3'b100;
        for (int i = 3; i >= 0; i--) begin
            if (mask[i] && (3'(i) >= from)) begin
                res = 3'(i);
            end
        end
        return res;
    endfunction : find_ch

    // Byte shown for a phase
    function automatic logic [7:0] byte_for(input state_t rs, input phase_t ph,
                                            input logic [1:0] ch);
        logic [15:0] word;
        word = {6'h00, rs.snap_a[ch*10 +: 10]};                      // [R8]
        case (ph)
            PH_SETCNT: byte_for = `SET_COUNT_BYTE;                   // [R2]
            PH_DMASKH: byte_for = {3'h0, rs.dmask[12:8]};            // [R3]
            PH_DMASKL: byte_for = rs.dmask[7:0];                     // [R3]
            PH_AMASK:  byte_for = {4'h0, rs.amask};                  // [R4]
            PH_DSTH:   byte_for = {3'h0, rs.snap_d[12:8]};
            PH_DSTL:   byte_for = rs.snap_d[7:0];
            PH_ANAH:   byte_for = word[15:8];
            PH_ANAL:   byte_for = word[7:0];
            default:   byte_for = 8'h00;
        endcase
    endfunction : byte_for

    logic        wr;
    logic        rd_acc;
    logic        any_line;
    logic        tick;
    logic        per_en;
    logic        per_fire;
    logic        gap_ok;
    logic        wake_rise;
    logic        wake_elapsed;
    logic [12:0] changed;
    logic        field_end;
    logic [2:0]  nch;
    logic        mapped;

    always_comb begin
        nxt_s = s_ff;
        wr = psel_in && penable_in && !s_ff.pready && pwrite_in;
        rd_acc = psel_in && penable_in && !s_ff.pready && !pwrite_in;
        any_line = (s_ff.dmask != 13'h0000) || (s_ff.amask != 4'h0);
        mapped = 1'b1;
        nch = 3'b100;
        field_end = 1'b0;

        // Pin synchronisers
        nxt_s.ln_s1 = digital_line_in;
        nxt_s.ln_s2 = s_ff.ln_s1;
        nxt_s.ln_prev = s_ff.ln_s2;
        nxt_s.awake_s1 = awake_in;
        nxt_s.awake_s2 = s_ff.awake_s1;
        nxt_s.awake_prev = s_ff.awake_s2;

        // Millisecond time base
        tick = (s_ff.tick_cnt == 16'(CYCLES_PER_MS - 1));
        nxt_s.tick_cnt = tick ? 16'h0000 : s_ff.tick_cnt + 16'h0001;
        if (tick && s_ff.gap != 2'd0) begin
            nxt_s.gap = s_ff.gap - 2'd1;
        end
        gap_ok = (s_ff.gap == 2'd0) || (tick && s_ff.gap == 2'd1);             // [R15]

        // Wake cycle divider
        wake_rise = s_ff.awake_s2 && !s_ff.awake_prev;
        wake_elapsed = (s_ff.wake_cnt + 8'h01) >=
                       ((s_ff.wake_div == 8'h00) ? 8'h01 : s_ff.wake_div);
        if (wake_rise) begin
            nxt_s.wake_ok = wake_elapsed;                                      // [R21]
            nxt_s.wake_cnt = wake_elapsed ? 8'h00 : s_ff.wake_cnt + 8'h01;
        end else if (!s_ff.awake_s2) begin
            nxt_s.wake_ok = 1'b0;
        end

        // Periodic timer runs only while awake on an elapsed wake cycle
        per_en = (s_ff.period != 16'h0000) && any_line && s_ff.awake_s2
                 && s_ff.wake_ok;                                              // [R14] [R19]
        per_fire = 1'b0;
        if (!per_en) begin
            nxt_s.ms_cnt = 16'h0000;
        end else if (tick) begin
            if (s_ff.ms_cnt + 16'h0001 >= s_ff.period) begin
                nxt_s.ms_cnt = 16'h0000;
                per_fire = 1'b1;
            end else begin
                nxt_s.ms_cnt = s_ff.ms_cnt + 16'h0001;
            end
        end

        changed = (s_ff.ln_s2 ^ s_ff.ln_prev) & s_ff.chg_mask & s_ff.dmask;

        // APB slave, answer in the second access cycle
        nxt_s.pready = psel_in && penable_in && !s_ff.pready;
        nxt_s.pslverr = 1'b0;
        nxt_s.prdata = 32'h0000_0000;
        case (paddr_in)
            `OFS_CTRL:         nxt_s.prdata = {31'h0, s_ff.text_mode};
            `OFS_DIGITAL_MASK: nxt_s.prdata = {19'h0, s_ff.dmask};
            `OFS_ANALOG_MASK:  nxt_s.prdata = {28'h0, s_ff.amask};
            `OFS_PERIOD_MS:    nxt_s.prdata = {16'h0, s_ff.period};
            `OFS_DEST_ADDR:    nxt_s.prdata = s_ff.dest;
            `OFS_DEST_OPT:     nxt_s.prdata = {24'h0, s_ff.dopt};
            `OFS_AREF_SEL:     nxt_s.prdata = {31'h0, s_ff.aref};
            `OFS_WAKE_DIV:     nxt_s.prdata = {24'h0, s_ff.wake_div};
            `OFS_CHANGE_MASK:  nxt_s.prdata = {19'h0, s_ff.chg_mask};
            `OFS_FORCE:        nxt_s.prdata = 32'h0000_0000;
            `OFS_STATUS:       nxt_s.prdata = {25'h0, s_ff.wake_ok, s_ff.pend,
                                               s_ff.phase != PH_IDLE};
            default:           mapped = 1'b0;
        endcase
        if (!(rd_acc || wr)) begin
            nxt_s.prdata = 32'h0000_0000;
        end
        if ((rd_acc || wr) && !mapped) begin
            nxt_s.pslverr = 1'b1;
        end
        if (wr) begin
            case (paddr_in)
                `OFS_CTRL:         nxt_s.text_mode = pwdata_in[`CTRL_TEXT_BIT];
                `OFS_DIGITAL_MASK: nxt_s.dmask = pwdata_in[12:0];
                `OFS_ANALOG_MASK:  nxt_s.amask = pwdata_in[3:0];
                `OFS_PERIOD_MS:    nxt_s.period = pwdata_in[15:0];
                `OFS_DEST_ADDR:    nxt_s.dest = pwdata_in;
                `OFS_DEST_OPT:     nxt_s.dopt = pwdata_in[7:0];
                `OFS_AREF_SEL:     nxt_s.aref = pwdata_in[0];                  // [R9]
                `OFS_WAKE_DIV:     nxt_s.wake_div = pwdata_in[7:0];
                `OFS_CHANGE_MASK:  nxt_s.chg_mask = pwdata_in[12:0];
                default:           nxt_s.text_mode = s_ff.text_mode;
            endcase
        end

        // Record serializer
        nxt_s.rec_end = 1'b0;
        nxt_s.err = 1'b0;
        if (s_ff.valid && rec_ready_in) begin
            field_end = (s_ff.phase == PH_SETCNT) || (s_ff.phase == PH_DMASKL) ||
                        (s_ff.phase == PH_AMASK) || (s_ff.phase == PH_DSTL) ||
                        (s_ff.phase == PH_ANAL);
            if (!s_ff.framed && field_end && !s_ff.sep) begin
                nxt_s.sep = 1'b1;                                              // [R13]
                nxt_s.data = `TEXT_SEP_BYTE;
            end else begin
                nxt_s.sep = 1'b0;
                nxt_s.phase = PH_IDLE;
                case (s_ff.phase)
                    PH_SETCNT: nxt_s.phase = PH_DMASKH;                        // [R1]
                    PH_DMASKH: nxt_s.phase = PH_DMASKL;
                    PH_DMASKL: nxt_s.phase = PH_AMASK;
                    PH_AMASK:  begin
                        if (s_ff.dmask != 13'h0000) begin
                            nxt_s.phase = PH_DSTH;                             // [R5]
                        end else begin
                            nch = find_ch(s_ff.amask, 3'd0);
                        end
                    end
                    PH_DSTH:   nxt_s.phase = PH_DSTL;
                    PH_DSTL:   nch = find_ch(s_ff.amask, 3'd0);
                    PH_ANAH:   nxt_s.phase = PH_ANAL;
                    PH_ANAL:   nch = find_ch(s_ff.amask, {1'b0, s_ff.ch} + 3'd1); // [R7]
                    default:   nxt_s.phase = PH_IDLE;
                endcase
                if (!nch[2]) begin
                    nxt_s.phase = PH_ANAH;
                    nxt_s.ch = nch[1:0];
                end
                if (nxt_s.phase == PH_IDLE) begin
                    nxt_s.valid = 1'b0;
                    nxt_s.rec_end = 1'b1;
                end
                nxt_s.data = byte_for(s_ff, nxt_s.phase, nxt_s.ch);
            end
        end

        // Trigger capture; pending triggers wait for the serializer
        if (s_ff.phase == PH_IDLE && !s_ff.valid) begin
            for (int t = 4; t >= 0; t--) begin
                if (s_ff.pend[t]) begin
                    nxt_s.src = trig_t'(t);
                end
            end
            if (s_ff.pend != 5'h00) begin
                nxt_s.pend[nxt_s.src] = 1'b0;
                nxt_s.route = '0;
                nxt_s.framed = 1'b1;
                case (nxt_s.src)
                    TR_LOCAL: begin
                        nxt_s.route.to_serial = 1'b1;                          // [R12]
                        nxt_s.framed = !s_ff.text_mode;                        // [R13]
                    end
                    TR_REMOTE: nxt_s.route.to_requester = 1'b1;                // [R12]
                    default: begin
                        nxt_s.route.to_cloud = s_ff.dopt[`OPT_CLOUD_BIT];      // [R16]
                        nxt_s.route.to_dest = !s_ff.dopt[`OPT_CLOUD_BIT] ||
                                              s_ff.dopt[`OPT_DEST_BIT];        // [R17]
                    end
                endcase
                if ((nxt_s.src == TR_LOCAL || nxt_s.src == TR_REMOTE) && !any_line) begin
                    nxt_s.err = 1'b1;                                          // [R11]
                    nxt_s.err_route = nxt_s.route;
                end else begin
                    nxt_s.snap_d = s_ff.ln_s2 & s_ff.dmask;                    // [R6] [R10]
                    nxt_s.snap_a = analog_channel_in;
                    nxt_s.phase = PH_SETCNT;
                    nxt_s.sep = 1'b0;
                    nxt_s.valid = 1'b1;
                    nxt_s.data = `SET_COUNT_BYTE;                              // [R2]
                    nxt_s.gap = `MIN_GAP_MS;                                   // [R15]
                end
            end
        end

        // New triggers set after the clear so none is lost
        if (wr && paddr_in == `OFS_FORCE) begin
            if (pwdata_in[`FORCE_LOCAL_BIT]) begin
                nxt_s.pend[TR_LOCAL] = 1'b1;                                   // [R10]
            end
            if (pwdata_in[`FORCE_REMOTE_BIT]) begin
                nxt_s.pend[TR_REMOTE] = 1'b1;
            end
        end
        if (wake_rise && wake_elapsed && any_line) begin
            nxt_s.pend[TR_WAKE] = 1'b1;                                        // [R20]
        end
        if (changed != 13'h0000) begin
            nxt_s.pend[TR_CHANGE] = 1'b1;                                      // [R22] [R23]
        end
        if (per_fire && gap_ok) begin
            nxt_s.pend[TR_PERIOD] = 1'b1;                                      // [R15] [R23]
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            s_ff <= '0;
            s_ff.aref <= `AREF_RESET;                                          // [R9]
            s_ff.phase <= PH_IDLE;
            s_ff.src <= TR_LOCAL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign pready_out = s_ff.pready;
    assign prdata_out = s_ff.prdata;
    assign pslverr_out = s_ff.pslverr;
    assign rec_valid_out = s_ff.valid;
    assign rec_data_out = s_ff.data;
    assign rec_end_out = s_ff.rec_end;
    assign rec_route_out = s_ff.route;
    assign rec_framed_out = s_ff.framed;
    assign force_error_out = s_ff.err;
    assign error_route_out = s_ff.err_route;
    assign destination_address_out = s_ff.dest;
    assign analog_reference_select_out = s_ff.aref;

endmodule : io_sample_framer

//--- bench/io_sample_framer_asserts.sv
// Concurrent checks on the record stream and error outputs of the framer
`timescale 1ns/1ps
module io_sample_framer_asserts
    import io_sample_framer_pkg::*;
(
    input wire logic       ref_clk_in,
    input wire logic       rst_n_in,
    input wire logic       rec_ready_in,
    input wire logic       rec_valid_out,
    input wire logic [7:0] rec_data_out,
    input wire logic       rec_end_out,
    input wire route_t     rec_route_out,
    input wire logic       rec_framed_out,
    input wire logic       force_error_out,
    input wire route_t     error_route_out,
    input wire logic       analog_reference_select_out
);
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    set_count_a: assert property ($rose(rec_valid_out) |-> rec_data_out == 8'h01)
        else $error("record does not open with set count one");
    data_hold_a: assert property (rec_valid_out && !rec_ready_in |=>
        rec_valid_out && $stable(rec_data_out))
        else $error("record byte dropped before acceptance");
    end_pulse_a: assert property (rec_end_out |->
        !rec_valid_out && $past(rec_valid_out) && $past(rec_ready_in))
        else $error("record end not after last accepted byte");
    aref_reset_a: assert property ($rose(rst_n_in) |-> analog_reference_select_out)
        else $error("reference select not full scale after reset");
    err_pulse_a: assert property (force_error_out |=> !force_error_out)
        else $error("force error longer than one cycle");
    err_route_a: assert property (force_error_out |->
        (error_route_out.to_serial || error_route_out.to_requester))
        else $error("force error without requester route");
    route_set_a: assert property (rec_valid_out |-> rec_route_out != 4'h0)
        else $error("record without destination");
    route_hold_a: assert property (rec_valid_out && $past(rec_valid_out) |->
        $stable(rec_route_out) && $stable(rec_framed_out))
        else $error("route changed inside a record");
    text_sep_a: assert property ($rose(rec_valid_out) && rec_ready_in &&
        !rec_framed_out |=> rec_data_out == 8'h0d)
        else $error("text record lacks separator after set count");
endmodule : io_sample_framer_asserts

bind io_sample_framer io_sample_framer_asserts u_asserts (
    .ref_clk_in,
    .rst_n_in,
    .rec_ready_in,
    .rec_valid_out,
    .rec_data_out,
    .rec_end_out,
    .rec_route_out,
    .rec_framed_out,
    .force_error_out,
    .error_route_out,
    .analog_reference_select_out
);

//--- bench/rec_sink.sv
// Record sink model standing for the serial host or remote requester
`timescale 1ns/1ps
module rec_sink
    import io_sample_framer_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       slow_in,
    input  wire logic       valid_in,
    input  wire logic [7:0] data_in,
    input  wire logic       end_in,
    input  wire route_t     route_in,
    input  wire logic       framed_in,
    output logic            ready_out
);
    logic [7:0] bytes[$];
    route_t     routes[$];
    logic       framed[$];
    int         ends = 0;
    logic       mid = 1'b0;
    logic       tog = 1'b0;

    // Slow mode accepts every other cycle
    assign ready_out = slow_in ? tog : 1'b1;

    always @(posedge clk_in) begin
        tog <= ~tog;
        if (!rst_n_in) begin
            mid <= 1'b0;
        end else begin
            if (valid_in && ready_out) begin
                bytes.push_back(data_in);
                if (!mid) begin
                    routes.push_back(route_in);
                    framed.push_back(framed_in);
                end
                mid <= 1'b1;
            end
            if (end_in) begin
                mid <= 1'b0;
                ends++;
            end
        end
    end
endmodule : rec_sink

//--- bench/io_sample_framer_test.sv
// Self-checking bench of the I/O sample framer
`timescale 1ns/1ps
`include "io_sample_framer_defs.svh"
module io_sample_framer_test import io_sample_framer_pkg::*;;
    localparam int CPM = 10;
    logic        ref_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [12:0] digital_line_in = 13'h0;
    logic [39:0] analog_channel_in = 40'h0;
    logic        awake_in = 1'b1;
    logic        slow = 1'b0;
    logic        rec_ready_in, pready_out, pslverr_out, rec_valid_out, rec_end_out;
    logic        rec_framed_out, force_error_out, analog_reference_select_out;
    logic [31:0] prdata_out, destination_address_out;
    logic [7:0]  rec_data_out;
    route_t      rec_route_out, error_route_out;
    int          bad_count = 0;
    int          checks = 0;
    int          cycles = 0;

    always #20 ref_clk_in = ~ref_clk_in;

    io_sample_framer #(.CYCLES_PER_MS(CPM)) u_dut (.ref_clk_in, .rst_n_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out,
        .pslverr_out, .digital_line_in, .analog_channel_in, .awake_in, .rec_ready_in,
        .rec_valid_out, .rec_data_out, .rec_end_out, .rec_route_out, .rec_framed_out,
        .force_error_out, .error_route_out, .destination_address_out,
        .analog_reference_select_out);

    rec_sink u_sink (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
        .valid_in(rec_valid_out), .data_in(rec_data_out), .end_in(rec_end_out),
        .route_in(rec_route_out), .framed_in(rec_framed_out), .ready_out(rec_ready_in));

    task automatic print_verdict();
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask : wr

    task automatic clr();
        u_sink.bytes.delete();
        u_sink.routes.delete();
        u_sink.framed.delete();
        u_sink.ends = 0;
    endtask : clr

    task automatic wait_recs(input int n, input int lim);
        repeat (lim) begin
            if (u_sink.ends < n) @(posedge ref_clk_in);
        end
        repeat (4) @(posedge ref_clk_in);
    endtask : wait_recs

    task automatic chk_bytes(input logic [7:0] exp[$]);
        chk(u_sink.bytes.size(), exp.size());
        foreach (exp[i]) chk(u_sink.bytes[i], exp[i]);
    endtask : chk_bytes

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, `OFS_AREF_SEL, 32'h0, r, e);
        chk(r, 32'h1);
        wr(`OFS_AREF_SEL, 32'h0);
        chk({31'h0, analog_reference_select_out}, 32'h0);
        wr(`OFS_AREF_SEL, 32'h1);
        wr(`OFS_DEST_ADDR, 32'h0a0b0c0d);
        chk(destination_address_out, 32'h0a0b0c0d);
        apb(1'b0, 8'hfc, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
    endtask : t_regs

    task automatic t_error();
        for (int b = 0; b < 2; b++) begin
            wr(`OFS_FORCE, 32'h1 << b);
            repeat (10) begin
                if (force_error_out !== 1'b1) @(posedge ref_clk_in);
            end
            chk({31'h0, force_error_out}, 32'h1);
            chk({28'h0, error_route_out}, b ? 32'h4 : 32'h8);
        end
        chk(u_sink.bytes.size(), 32'h0);
    endtask : t_error

    task automatic t_text();
        analog_channel_in <= {10'h3ff, 10'h155, 10'h124, 10'h3d0};
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_ANALOG_MASK, 32'h1);
        clr();
        wr(`OFS_FORCE, 32'h1);
        wait_recs(1, 200);
        chk_bytes('{8'h01, 8'h0d, 8'h00, 8'h00, 8'h0d, 8'h01, 8'h0d, 8'h03, 8'hd0, 8'h0d});
        chk({31'h0, u_sink.framed[0]}, 32'h0);
        wr(`OFS_CTRL, 32'h0);
    endtask : t_text

    task automatic t_framed();
        digital_line_in <= 13'h1408;
        slow <= 1'b1;
        wr(`OFS_DIGITAL_MASK, 32'h0c0c);
        wr(`OFS_ANALOG_MASK, 32'h9);
        clr();
        wr(`OFS_FORCE, 32'h1);
        wr(`OFS_FORCE, 32'h2);
        wait_recs(2, 400);
        chk_bytes('{8'h01, 8'h0c, 8'h0c, 8'h09, 8'h04, 8'h08, 8'h03, 8'hd0, 8'h03, 8'hff,
                    8'h01, 8'h0c, 8'h0c, 8'h09, 8'h04, 8'h08, 8'h03, 8'hd0, 8'h03, 8'hff});
        chk({28'h0, u_sink.routes[0], u_sink.routes[1]}, 32'h84);
        chk({31'h0, u_sink.framed[1]}, 32'h1);
        slow <= 1'b0;
    endtask : t_framed

    task automatic t_change();
        wr(`OFS_CHANGE_MASK, 32'h4);
        clr();
        digital_line_in <= 13'h140c;
        wait_recs(1, 60);
        chk(u_sink.ends, 32'h1);
        chk(u_sink.bytes[5], 32'h0c);
        clr();
        digital_line_in <= 13'h140d;
        repeat (60) @(posedge ref_clk_in);
        chk(u_sink.ends, 32'h0);
    endtask : t_change

    task automatic t_wake();
        for (int k = 0; k < 3; k++) begin
            if (k == 1) wr(`OFS_WAKE_DIV, 32'h2);
            awake_in <= 1'b0;
            repeat (10) @(posedge ref_clk_in);
            clr();
            awake_in <= 1'b1;
            repeat (60) @(posedge ref_clk_in);
            chk(u_sink.ends, {31'h0, k != 1});
        end
    endtask : t_wake

    task automatic t_periodic();
        wr(`OFS_DEST_OPT, 32'h09);
        wr(`OFS_PERIOD_MS, 32'h3);
        clr();
        repeat (CPM * 30) @(posedge ref_clk_in);
        chk(u_sink.ends >= 9 && u_sink.ends <= 11, 32'h1);
        chk({27'h0, u_sink.framed[0], u_sink.routes[0]}, 32'h13);
        wr(`OFS_DEST_OPT, 32'h08);
        wr(`OFS_PERIOD_MS, 32'h1);
        clr();
        repeat (CPM * 30) @(posedge ref_clk_in);
        chk(u_sink.ends >= 7 && u_sink.ends <= 11, 32'h1);
        chk({28'h0, u_sink.routes[0]}, 32'h2);
        wr(`OFS_PERIOD_MS, 32'h0);
        repeat (40) @(posedge ref_clk_in);
        clr();
        repeat (CPM * 30) @(posedge ref_clk_in);
        chk(u_sink.ends, 32'h0);
    endtask : t_periodic

    initial begin
        repeat (5) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_error();
        t_text();
        t_framed();
        t_change();
        t_wake();
        t_periodic();
        print_verdict();
    end

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
endmodule : io_sample_framer_test
